// *** sim/tb_uhcis_reg_bank.sv ***
// Self-checking bench for the command/status and event flag bank
`timescale 1ns/1ns
module tb_uhcis_reg_bank;
	import uhcis_pkg::*;
	localparam int HOLD = 4;
	logic        clk = 1'b0, rst = 1'b1, cmdStrobe, rdValid, irqReq, sofStrobe, busy;
	logic        enterSuspend, halt, v, overrunDetect = 1'b0, sysErrorDetect = 1'b0;
	logic        resumeLine = 1'b0, swResumeEntry = 1'b0, frameStart = 1'b0;
	logic [7:0]  cmdCode;
	logic [15:0] frameCount = 16'h0;
	logic [1:0]  expCnt = 2'h0;
	logic [31:0] cmdWrData, rdData, rd, eventEnable = 32'h0, rootHubState = 32'h0;
	logic [31:0] portState [2] = '{32'h0, 32'h0};
	logic [31:0] rowEn [7] = '{32'h8000_0001, 32'h0000_0004, 32'h8000_0004,
		32'h8000_0020, 32'h8000_0040, 32'h8000_007D, 32'h8000_0010};
	logic [6:0]  rowFlag [7] = '{7'h01, 7'h04, 7'h08, 7'h20, 7'h40, 7'h40, 7'h10};
	int          errors = 0, comparisons = 0, cyc;

	always #10 clk = ~clk;

	uhcis_reg_bank #(.RESET_HOLD(HOLD)) i_uhcis_reg_bank (.clk(clk), .rst(rst),
		.cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
		.eventEnable(eventEnable), .overrunDetect(overrunDetect),
		.rootHubState(rootHubState), .rootPortState(portState), .frameCount(frameCount),
		.sysErrorDetect(sysErrorDetect), .resumeLine(resumeLine),
		.swResumeEntry(swResumeEntry), .frameStart(frameStart), .rdData(rdData),
		.rdValid(rdValid), .irqReq(irqReq), .sofStrobe(sofStrobe),
		.softResetBusy(busy), .enterSuspend(enterSuspend), .haltProcessing(halt));
	uhcis_host_model i_uhcis_host_model (.clk(clk), .busy(busy), .rdData(rdData),
		.rdValid(rdValid), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
		.cmdWrData(cmdWrData));

	// ------------------------------------------------------------------
	// Compare, access and event tasks
	// ------------------------------------------------------------------
	task automatic chk32(input string name, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk32

	task automatic chk1(input string name, input logic exp, got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1

	task automatic readReg(input logic [7:0] code, input logic [31:0] exp);
		i_uhcis_host_model.access(code, 32'h0, rd, v);
		chk1("rdValid", 1'b1, v);
		chk32("rdData", exp, rd);
	endtask : readReg

	// Raise one event for a cycle; frame count and state words keep their new value
	task automatic fire(input int idx);
		@(posedge clk);
		#2;
		case (idx)
			0: overrunDetect = 1'b1;
			1: frameStart = 1'b1;
			2: resumeLine = 1'b1;
			3: frameCount = frameCount ^ 16'h8000;
			4: rootHubState = ~rootHubState;
			5: portState[1] = portState[1] + 32'h1;
			default: sysErrorDetect = 1'b1;
		endcase
		if (idx == 0) expCnt++;
		@(posedge clk);
		#2 chk1("sofStrobe", idx == 1, sofStrobe);
		overrunDetect = 1'b0;
		frameStart = 1'b0;
		sysErrorDetect = 1'b0;
		resumeLine = 1'b0;
	endtask : fire

	task automatic test_done;
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		test_done;
	end

	// Main sequence: reset, event rows, then the awkward cases
	initial begin
		repeat (8) @(posedge clk);
		#2 rst = 1'b0;
		repeat (3) @(posedge clk);
		readReg(UHCIS_CODE_CMD_RD, 32'h0);
		readReg(UHCIS_CODE_EVT_RD, 32'h0);
		for (int i = 0; i < 7; i++) begin
			i_uhcis_host_model.clearFlags(32'h6D);
			eventEnable = rowEn[i];
			fire(i);
			readReg(UHCIS_CODE_EVT_RD, {25'h0, rowFlag[i]});
			chk1("irqReq", rowEn[i][31] & |(rowEn[i][6:0] & rowFlag[i]), irqReq);
			chk1("halt", rowFlag[i][4], halt);
			readReg(UHCIS_CODE_CMD_RD, {14'h0, expCnt, 16'h0});
		end
		for (int k = 0; k < 3; k++) fire(0);
		readReg(UHCIS_CODE_CMD_RD, {14'h0, expCnt, 16'h0});
		i_uhcis_host_model.access(UHCIS_CODE_CMD_WR, 32'hFFFF_FFFE, rd, v);
		chk1("wrAnswer", 1'b0, v);
		readReg(UHCIS_CODE_CMD_RD, {14'h0, expCnt, 16'h0});
		i_uhcis_host_model.access(UHCIS_CODE_EVT_WR, 32'hFFFF_FF82, rd, v);
		readReg(UHCIS_CODE_EVT_RD, 32'h11);
		readReg(8'h07, 32'h0);
		eventEnable = 32'h8000_0001;
		repeat (3) @(posedge clk);
		#2 chk1("irqHeld", 1'b1, irqReq);
		eventEnable = 32'h0000_0011;
		repeat (2) @(posedge clk);
		#2 chk1("irqMaster", 1'b0, irqReq);
		eventEnable = 32'h8000_0010;
		swResumeEntry = 1'b1;
		fire(2);
		swResumeEntry = 1'b0;
		readReg(UHCIS_CODE_EVT_RD, 32'h11);
		fire(0);
		i_uhcis_host_model.access(UHCIS_CODE_CMD_WR, 32'h0000_0001, rd, v);
		chk1("enterSuspend", 1'b1, enterSuspend);
		chk1("busy", 1'b1, busy);
		i_uhcis_host_model.waitIdle(cyc);
		chk32("busyCycles", HOLD, cyc);
		expCnt = 2'h0;
		readReg(UHCIS_CODE_CMD_RD, 32'h0);
		readReg(UHCIS_CODE_EVT_RD, 32'h11);
		i_uhcis_host_model.clearFlags(32'h10);
		readReg(UHCIS_CODE_EVT_RD, 32'h01);
		chk1("halt", 1'b0, halt);
		chk1("irqCleared", 1'b0, irqReq);
		// Clear and frame start land on one edge: the set must win
		fork
			i_uhcis_host_model.access(UHCIS_CODE_EVT_WR, 32'h0000_0004, rd, v);
			fire(1);
		join
		readReg(UHCIS_CODE_EVT_RD, 32'h05);
		fire(0);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#2 rst = 1'b0;
		repeat (3) @(posedge clk);
		readReg(UHCIS_CODE_EVT_RD, 32'h0);
		readReg(UHCIS_CODE_CMD_RD, 32'h0);
		test_done;
	end
endmodule : tb_uhcis_reg_bank

// *** sim/uhcis_host_model.sv ***
// Host driver model issuing register commands to the bank
`timescale 1ns/1ns
module uhcis_host_model
	import uhcis_pkg::*;
(
	input  wire logic        clk,       // Controller clock
	input  wire logic        busy,      // Soft reset in progress
	input  wire logic [31:0] rdData,    // Read data
	input  wire logic        rdValid,   // Read data valid
	output logic             cmdStrobe, // Command valid
	output logic      [7:0]  cmdCode,   // Command code
	output logic      [31:0] cmdWrData  // Write data
);
	// Idle bus at time zero
	initial begin
		cmdStrobe = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 32'h0;
	end

	// Wait out a soft reset, counting its cycles
	task automatic waitIdle(output int cyc);
		cyc = 0;
		while (busy === 1'b1 && cyc < 600) begin
			@(posedge clk);
			#2 cyc++;
		end
	endtask : waitIdle

	// One command held over one edge; never issued while busy
	task automatic access(input logic [7:0] code, input logic [31:0] data,
		output logic [31:0] rd, output logic v);
		int n;
		waitIdle(n);
		@(posedge clk);
		#2 cmdStrobe = 1'b1;
		cmdCode = code;
		cmdWrData = data;
		@(posedge clk);
		#2 cmdStrobe = 1'b0;
		cmdCode = ~code;
		cmdWrData = ~data;
		rd = rdData;
		v = rdValid;
	endtask : access

	// Clear flags; the fatal flag only after a soft reset
	task automatic clearFlags(input logic [31:0] mask);
		logic [31:0] d;
		logic        v;
		int          n;
		if (mask[UHCIS_FATAL_BIT]) begin
			access(UHCIS_CODE_CMD_WR, 32'h0000_0001, d, v);
			waitIdle(n);
		end
		access(UHCIS_CODE_EVT_WR, mask, d, v);
	endtask : clearFlags
endmodule : uhcis_host_model

// *** verilog/uhcis_event_detect.sv ***
// Event detector turning controller activity into flag set pulses
`timescale 1ns/1ns
module uhcis_event_detect
	import uhcis_pkg::*;
#(
	parameter int PORTS = UHCIS_PORTS
) (
	input  wire logic        clk,                        // Controller clock
	input  wire logic        rst,                        // Synchronous reset
	input  wire logic        overrunDetect,              // Schedule overrun pulse
	input  wire logic [31:0] rootHubState,               // Root hub state word
	input  wire logic [31:0] rootPortState [PORTS],      // Root port state words
	input  wire logic [15:0] frameCount,                 // Frame counter value
	input  wire logic        sysErrorDetect,             // System error pulse
	input  wire logic        resumeLine,                 // Downstream resume seen
	input  wire logic        swResumeEntry,              // Software moves to resume
	input  wire logic        frameStart,                 // Frame start pulse
	uhcis_evt_if.src         evt                         // Set pulses out
);
	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	if (PORTS < 1) begin : g_bad_ports
		$error("uhcis_event_detect needs at least one port");
	end

	logic             primed_reg;
	logic [31:0]      hubPrev_reg;
	logic             frameMsbPrev_reg;
	logic             resumePrev_reg;
	logic [PORTS-1:0] portChange;
	logic             hubChange;
	logic             resumeRise;

	// First sample after reset only loads history, so no false change
	always_ff @(posedge clk) begin
		if (rst) begin
			primed_reg <= 1'b0;
		end else begin
			primed_reg <= 1'b1;
		end
	end

	// History of hub word, frame MSB and resume line
	always_ff @(posedge clk) begin
		if (rst) begin
			hubPrev_reg      <= 32'h0000_0000;
			frameMsbPrev_reg <= 1'b0;
			resumePrev_reg   <= 1'b0;
		end else begin
			hubPrev_reg      <= rootHubState;
			frameMsbPrev_reg <= frameCount[UHCIS_FRAME_MSB];
			resumePrev_reg   <= resumeLine;
		end
	end

	// Per-port content change detection
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		logic [31:0] portPrev_reg;
		always_ff @(posedge clk) begin
			if (rst) begin
				portPrev_reg <= 32'h0000_0000;
			end else begin
				portPrev_reg <= rootPortState[p];
			end
		end
		assign portChange[p] = primed_reg && (portPrev_reg != rootPortState[p]);
	end

	// Hub change and resume onset; only the resume onset is suppressed for software resume entry
	assign hubChange  = (primed_reg && (hubPrev_reg != rootHubState)) || (|portChange);
	assign resumeRise = primed_reg && resumeLine && !resumePrev_reg && !swResumeEntry;

	// Set vector, one bit per flag position
	always_comb begin
		evt.setVec                       = '0;
		evt.setVec[UHCIS_SCHED_OVR_BIT]  = overrunDetect;
		evt.setVec[UHCIS_FRAME_SOF_BIT]  = frameStart;
		evt.setVec[UHCIS_RESUME_BIT]     = resumeRise;
		evt.setVec[UHCIS_FATAL_BIT]      = sysErrorDetect;
		evt.setVec[UHCIS_FRAME_WRAP_BIT] = primed_reg &&
			(frameMsbPrev_reg != frameCount[UHCIS_FRAME_MSB]);
		evt.setVec[UHCIS_HUB_CHG_BIT]    = hubChange;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_resume_sw_block: assert property (@(posedge clk) disable iff (rst)
		swResumeEntry |-> !evt.setVec[UHCIS_RESUME_BIT])
		else $error("resume flag set on software resume entry");
	a_frame_wrap_set: assert property (@(posedge clk) disable iff (rst)
		(primed_reg && $changed(frameCount[UHCIS_FRAME_MSB]))
		|-> evt.setVec[UHCIS_FRAME_WRAP_BIT])
		else $error("frame MSB toggle missed");
endmodule : uhcis_event_detect

// *** verilog/uhcis_evt_if.sv ***
// Event set pulses passed from the event detector to the register bank
`timescale 1ns/1ns
interface uhcis_evt_if;
	import uhcis_pkg::*;
	logic [UHCIS_FLAG_W-1:0] setVec;	// One-cycle set requests per flag
	modport src (output setVec);
	modport dst (input setVec);
endinterface : uhcis_evt_if

// *** verilog/uhcis_pkg.sv ***
// Shared constants for the command/status and event flag register block
package uhcis_pkg;
	// ------------------------------------------------------------------
	// Command codes on the host register port
	// ------------------------------------------------------------------
	localparam logic [7:0]  UHCIS_CODE_CMD_RD   = 8'h02;
	localparam logic [7:0]  UHCIS_CODE_CMD_WR   = 8'h82;
	localparam logic [7:0]  UHCIS_CODE_EVT_RD   = 8'h03;
	localparam logic [7:0]  UHCIS_CODE_EVT_WR   = 8'h83;
	localparam logic [7:0]  UHCIS_CODE_WR_BIT   = 8'h80;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          UHCIS_SOFT_RST_BIT  = 0;
	localparam int          UHCIS_OVR_CNT_LSB   = 16;
	localparam int          UHCIS_OVR_CNT_W     = 2;
	localparam int          UHCIS_FLAG_W        = 7;
	localparam int          UHCIS_SCHED_OVR_BIT = 0;
	localparam int          UHCIS_FRAME_SOF_BIT = 2;
	localparam int          UHCIS_RESUME_BIT    = 3;
	localparam int          UHCIS_FATAL_BIT     = 4;
	localparam int          UHCIS_FRAME_WRAP_BIT = 5;
	localparam int          UHCIS_HUB_CHG_BIT   = 6;
	localparam int          UHCIS_MASTER_EN_BIT = 31;
	localparam int          UHCIS_FRAME_MSB     = 15;
	localparam logic [6:0]  UHCIS_FLAG_MASK     = 7'h7D;
	localparam int          UHCIS_PORTS         = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [6:0]  UHCIS_FLAGS_RST     = 7'h00;
	localparam logic [1:0]  UHCIS_OVR_CNT_RST   = 2'h0;
	localparam logic [31:0] UHCIS_RD_RST        = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int          UHCIS_CLK_MHZ       = 50;
	localparam int          UHCIS_SOFT_RST_NS   = 10000;
	localparam int          UHCIS_SOFT_RST_MAX_CYC = (UHCIS_SOFT_RST_NS * UHCIS_CLK_MHZ) / 1000;
	localparam int          UHCIS_SOFT_RST_HOLD = 16;

	// Soft reset sequencer states
	typedef enum logic {UHCIS_RST_IDLE, UHCIS_RST_RUN} uhcis_rst_state_t;
endpackage : uhcis_pkg

// *** verilog/uhcis_reg_bank.sv ***
// Command/status and event flag register bank with interrupt request
//
// Contract
// - Overrun count field increments per overrun.
// - Count starts zero, wraps from three.
// - Count increments even if overrun flag set.
// - Soft reset enters suspend, clears operational state.
// - Hardware clears reset bit when done.
// - Soft reset finishes within ten microseconds.
// - Soft reset leaves root hub, ports alone.
// - Events set their matching status flag.
// - Interrupt when flag, enable, master all set.
// - Write one clears flag; zero keeps.
// - Hardware only sets flags, never clears.
// - Flag six on root hub/port change.
// - Flag five on frame MSB toggle.
// - Flag four on system error; halt.
// - Flag three on resume signalling onset.
// - No resume flag on software resume.
// - Frame start emits SOF, sets flag two.
// - Flag zero on overrun, also counts.
// - Command register writes are write-to-set.
// - Master enable bit gates all interrupts.
`timescale 1ns/1ns
module uhcis_reg_bank
	import uhcis_pkg::*;
#(
	parameter int PORTS      = UHCIS_PORTS,
	parameter int RESET_HOLD = UHCIS_SOFT_RST_HOLD
) (
	input  wire logic        clk,                       // Controller clock
	input  wire logic        rst,                       // Synchronous reset
	input  wire logic        cmdStrobe,                 // Command code valid
	input  wire logic [7:0]  cmdCode,                   // Register command code
	input  wire logic [31:0] cmdWrData,                 // Write data
	input  wire logic [31:0] eventEnable,               // Enable register value
	input  wire logic        overrunDetect,             // Schedule overrun pulse
	input  wire logic [31:0] rootHubState,              // Root hub state word
	input  wire logic [31:0] rootPortState [PORTS],     // Root port state words
	input  wire logic [15:0] frameCount,                // Frame counter value
	input  wire logic        sysErrorDetect,            // System error pulse
	input  wire logic        resumeLine,                // Downstream resume seen
	input  wire logic        swResumeEntry,             // Software enters resume
	input  wire logic        frameStart,                // Frame start pulse
	output logic      [31:0] rdData,                    // Read data
	output logic             rdValid,                   // Read data valid pulse
	output logic             irqReq,                    // Interrupt request level
	output logic             sofStrobe,                 // SOF generate pulse
	output logic             softResetBusy,             // Soft reset in progress
	output logic             enterSuspend,              // Go to suspend pulse
	output logic             haltProcessing             // Halt on fatal error
);
	// ------------------------------------------------------------------
	// Elaboration check and local constants
	// ------------------------------------------------------------------
	if (RESET_HOLD < 1 || RESET_HOLD > UHCIS_SOFT_RST_MAX_CYC) begin : g_bad_hold
		$error("RESET_HOLD must lie within the soft reset time limit");
	end

	localparam int       HOLD_W     = $clog2(UHCIS_SOFT_RST_MAX_CYC + 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD - 1);
	localparam int       ResetLimitA = 500;

	// ------------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------------
	uhcis_evt_if evtBus ();

	uhcis_event_detect #(
		.PORTS         (PORTS)
	) u_detect (
		.clk           (clk),
		.rst           (rst),
		.overrunDetect (overrunDetect),
		.rootHubState  (rootHubState),
		.rootPortState (rootPortState),
		.frameCount    (frameCount),
		.sysErrorDetect(sysErrorDetect),
		.resumeLine    (resumeLine),
		.swResumeEntry (swResumeEntry),
		.frameStart    (frameStart),
		.evt           (evtBus.src)
	);

	logic [UHCIS_FLAG_W-1:0]    setVec;
	logic [UHCIS_FLAG_W-1:0]    flags_reg;
	logic [UHCIS_FLAG_W-1:0]    flags_next;
	logic [UHCIS_FLAG_W-1:0]    clearVec;
	logic [UHCIS_OVR_CNT_W-1:0] ovrCount_reg;
	uhcis_rst_state_t           rstState_reg;
	logic [HOLD_W-1:0]          holdCnt_reg;
	logic                       startReset;
	logic                       evtWrite;
	logic                       irq_next;
	logic [31:0]                rdData_reg;
	logic                       rdValid_reg;
	logic                       irqReq_reg;
	logic                       sofStrobe_reg;
	logic                       enterSuspend_reg;
	logic                       haltProcessing_reg;
	logic                       softResetBusy_reg;

	assign setVec = evtBus.setVec;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	// Host writes during a soft reset are ignored rather than queued; reads are still answered
	assign startReset = cmdStrobe && (cmdCode == UHCIS_CODE_CMD_WR) &&
		cmdWrData[UHCIS_SOFT_RST_BIT] && (rstState_reg == UHCIS_RST_IDLE);
	assign evtWrite   = cmdStrobe && (cmdCode == UHCIS_CODE_EVT_WR) &&
		(rstState_reg == UHCIS_RST_IDLE);
	assign clearVec   = evtWrite ? (cmdWrData[UHCIS_FLAG_W-1:0] & UHCIS_FLAG_MASK)
		: {UHCIS_FLAG_W{1'b0}};

	// ------------------------------------------------------------------
	// Soft reset sequencer
	// ------------------------------------------------------------------
	// Holds the busy bit for RESET_HOLD cycles, then clears it itself;
	// it drives no reset towards the root hub or downstream ports
	always_ff @(posedge clk) begin
		if (rst) begin
			rstState_reg <= UHCIS_RST_IDLE;
			holdCnt_reg  <= '0;
		end else begin
			unique case (rstState_reg)
				UHCIS_RST_IDLE: begin
					holdCnt_reg <= '0;
					if (startReset) begin
						rstState_reg <= UHCIS_RST_RUN;
					end
				end
				UHCIS_RST_RUN: begin
					if (holdCnt_reg == HOLD_LAST) begin
						rstState_reg <= UHCIS_RST_IDLE;
						holdCnt_reg  <= '0;
					end else begin
						holdCnt_reg <= holdCnt_reg + 1'b1;
					end
				end
			endcase
		end
	end

	// Busy flag kept in its own flop so the output is registered
	always_ff @(posedge clk) begin
		if (rst) begin
			softResetBusy_reg <= 1'b0;
		end else if (startReset) begin
			softResetBusy_reg <= 1'b1;
		end else if (rstState_reg == UHCIS_RST_RUN && holdCnt_reg == HOLD_LAST) begin
			softResetBusy_reg <= 1'b0;
		end
	end

	// Suspend entry pulse on the start of a soft reset
	always_ff @(posedge clk) begin
		if (rst) begin
			enterSuspend_reg <= 1'b0;
		end else begin
			enterSuspend_reg <= startReset;
		end
	end

	// ------------------------------------------------------------------
	// Scheduling overrun counter
	// ------------------------------------------------------------------
	// Counts regardless of the overrun flag; soft reset clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			ovrCount_reg <= UHCIS_OVR_CNT_RST;
		end else if (startReset) begin
			ovrCount_reg <= UHCIS_OVR_CNT_RST;
		end else if (setVec[UHCIS_SCHED_OVR_BIT]) begin
			ovrCount_reg <= ovrCount_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------------
	// A set arriving with its clear wins, so no event is lost
	always_comb begin
		flags_next = ((flags_reg & ~clearVec) | setVec) & UHCIS_FLAG_MASK;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_reg <= UHCIS_FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt, SOF and halt outputs
	// ------------------------------------------------------------------
	assign irq_next = eventEnable[UHCIS_MASTER_EN_BIT] &&
		(|(flags_next & eventEnable[UHCIS_FLAG_W-1:0]));

	always_ff @(posedge clk) begin
		if (rst) begin
			irqReq_reg         <= 1'b0;
			sofStrobe_reg      <= 1'b0;
			haltProcessing_reg <= 1'b0;
		end else begin
			irqReq_reg         <= irq_next;
			sofStrobe_reg      <= setVec[UHCIS_FRAME_SOF_BIT];
			haltProcessing_reg <= flags_next[UHCIS_FATAL_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Answer one cycle after the strobe; unknown codes read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_reg  <= UHCIS_RD_RST;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= cmdStrobe && ((cmdCode & UHCIS_CODE_WR_BIT) == 8'h00);
			if (cmdStrobe && cmdCode == UHCIS_CODE_CMD_RD) begin
				rdData_reg <= 32'h0000_0000;
				rdData_reg[UHCIS_OVR_CNT_LSB +: UHCIS_OVR_CNT_W] <= ovrCount_reg;
				rdData_reg[UHCIS_SOFT_RST_BIT] <= (rstState_reg == UHCIS_RST_RUN);
			end else if (cmdStrobe && cmdCode == UHCIS_CODE_EVT_RD) begin
				rdData_reg <= {25'h0000000, flags_reg};
			end else if (cmdStrobe) begin
				rdData_reg <= 32'h0000_0000;
			end
		end
	end

	assign rdData         = rdData_reg;
	assign rdValid        = rdValid_reg;
	assign irqReq         = irqReq_reg;
	assign sofStrobe      = sofStrobe_reg;
	assign softResetBusy  = softResetBusy_reg;
	assign enterSuspend   = enterSuspend_reg;
	assign haltProcessing = haltProcessing_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_count_increments: assert property (@(posedge clk) disable iff (rst)
		(setVec[UHCIS_SCHED_OVR_BIT] && !startReset)
		|=> ovrCount_reg == 2'($past(ovrCount_reg) + 2'h1))
		else $error("overrun count did not increment");
	a_count_wraps: assert property (@(posedge clk) disable iff (rst)
		(ovrCount_reg == 2'h3 && setVec[UHCIS_SCHED_OVR_BIT] && !startReset)
		|=> ovrCount_reg == 2'h0)
		else $error("overrun count did not wrap");
	a_count_flag_set: assert property (@(posedge clk) disable iff (rst)
		(flags_reg[UHCIS_SCHED_OVR_BIT] && setVec[UHCIS_SCHED_OVR_BIT] && !startReset)
		|=> ovrCount_reg != $past(ovrCount_reg))
		else $error("count stuck while overrun flag set");
	a_reset_suspend: assert property (@(posedge clk) disable iff (rst)
		startReset |=> enterSuspend && softResetBusy && ovrCount_reg == 2'h0)
		else $error("soft reset did not enter suspend");
	a_reset_completes: assert property (@(posedge clk) disable iff (rst)
		$rose(softResetBusy) |-> ##[1:ResetLimitA] !softResetBusy)
		else $error("soft reset exceeded time limit");
	a_flag_sets: assert property (@(posedge clk) disable iff (rst)
		setVec[UHCIS_HUB_CHG_BIT] |=> flags_reg[UHCIS_HUB_CHG_BIT])
		else $error("event did not set its flag");
	a_irq_gating: assert property (@(posedge clk) disable iff (rst)
		(!eventEnable[UHCIS_MASTER_EN_BIT] ##1 !eventEnable[UHCIS_MASTER_EN_BIT])
		|-> !irqReq)
		else $error("interrupt without master enable");
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		(irqReq && $stable(eventEnable) && !evtWrite) |=> irqReq)
		else $error("interrupt dropped without clear");
	a_w1c_clears: assert property (@(posedge clk) disable iff (rst)
		(evtWrite && cmdWrData[UHCIS_RESUME_BIT] && !setVec[UHCIS_RESUME_BIT])
		|=> !flags_reg[UHCIS_RESUME_BIT])
		else $error("write one did not clear flag");
	a_no_hw_clear: assert property (@(posedge clk) disable iff (rst)
		$fell(flags_reg[UHCIS_FATAL_BIT]) |-> $past(clearVec[UHCIS_FATAL_BIT]))
		else $error("flag cleared without software write");
	a_sof_and_flag: assert property (@(posedge clk) disable iff (rst)
		setVec[UHCIS_FRAME_SOF_BIT] |=> sofStrobe && flags_reg[UHCIS_FRAME_SOF_BIT])
		else $error("frame start missed SOF or flag");
	a_halt_follows: assert property (@(posedge clk) disable iff (rst)
		setVec[UHCIS_FATAL_BIT] |=> haltProcessing)
		else $error("fatal error did not halt");
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		rdValid |-> (rdData & 32'hFFFC_FF82) == 32'h0000_0000)
		else $error("reserved bits read non-zero");
	a_resume_sw_flag: assert property (@(posedge clk) disable iff (rst)
		(swResumeEntry && !flags_reg[UHCIS_RESUME_BIT]) |=> !flags_reg[UHCIS_RESUME_BIT])
		else $error("resume flag set on software resume entry");
	a_busy_ignores: assert property (@(posedge clk) disable iff (rst)
		(softResetBusy && cmdStrobe && cmdCode == UHCIS_CODE_EVT_WR && setVec == '0)
		|=> flags_reg == $past(flags_reg))
		else $error("flag write taken during soft reset");

	c_soft_reset: cover property (@(posedge clk) disable iff (rst)
		startReset ##1 softResetBusy ##[1:ResetLimitA] !softResetBusy);
	c_count_wrap: cover property (@(posedge clk) disable iff (rst)
		ovrCount_reg == 2'h3 ##1 ovrCount_reg == 2'h0);
	c_irq_raise: cover property (@(posedge clk) disable iff (rst) $rose(irqReq));
	c_set_wins: cover property (@(posedge clk) disable iff (rst)
		(|(clearVec & setVec)));
endmodule : uhcis_reg_bank
